// ---- rtl/sarcc_device.sv ----
`timescale 1ns/1ps
module sarcc_device (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Link
    sarcc_link.device link,
    // Analog core side
    input wire logic signed [15:0] sample_code,
    output logic input_connected,
    output logic hold_strobe,
    output logic converter_powered,
    output logic analog_outputs_powered
);
    // Bit of each pin in the synchroniser bank
    localparam int pin_count = 5;
    localparam int pin_start = 4;
    localparam int pin_reset = 3;
    localparam int pin_apd = 2;
    localparam int pin_cs = 1;
    localparam int pin_rd = 0;
    // Strobes idle high; reset and powerdowns seen active
    localparam logic [4:0] pin_reset_level = 5'h13;
    logic [4:0] pin_raw, pin_safe;
    logic start_fall, in_reset, start_high, read_on, apd_low;
    sarcc_pkg::sarcc_phase_type phase, next_phase;
    logic [sarcc_pkg::count_width-1:0] count, next_count;
    logic [sarcc_pkg::count_width-1:0] low_count, next_low_count;
    logic [15:0] held, next_held, result, next_result;
    logic [15:0] bus_out, next_bus_out;
    logic bus_en, next_bus_en, busy_q, next_busy, pd_q, next_pd;
    logic start_prev, next_start_prev, aout_on, next_aout_on;
    logic connected, next_connected, hold_q, next_hold;

    // Capture and reconnection both key off the sample phase
    function automatic logic is_sampling(
        input sarcc_pkg::sarcc_phase_type p
    );
        return p == sarcc_pkg::sarcc_sample;
    endfunction : is_sampling

    assign pin_raw = {link.conversion_start_n, link.reset_powerdown_n,
        link.analog_output_powerdown_n, link.chip_select_n, link.read_n};

    // Pins are asynchronous: two flops before use
    for (genvar i = 0; i < pin_count; i++) begin : g_sync
        logic meta, safe, next_meta, next_safe;
        always_comb begin
            next_meta = pin_raw[i];
            next_safe = meta;
        end
        always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
                meta <= pin_reset_level[i];
                safe <= pin_reset_level[i];
            end else begin
                meta <= next_meta;
                safe <= next_safe;
            end
        end
        assign pin_safe[i] = safe;
    end

    assign start_high = pin_safe[pin_start];
    assign in_reset = !pin_safe[pin_reset];
    assign apd_low = !pin_safe[pin_apd];
    assign read_on = !pin_safe[pin_cs] && !pin_safe[pin_rd];
    assign start_fall = start_prev && !start_high;

    // Long low on the reset pin also powers the converter down
    always_comb begin
        next_low_count = '0;
        next_pd = 1'b0;
        if (in_reset) begin
            next_low_count = low_count;
            next_pd = pd_q;
            if (low_count < sarcc_pkg::count_width'(
                    sarcc_pkg::powerdown_low_cycles))
                next_low_count = low_count + 1'b1;
            else
                next_pd = 1'b1;
        end
        // Analog outputs drop only with both powerdowns
        next_aout_on = !(next_pd && apd_low);
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            low_count <= '0;
            pd_q <= 1'b0;
            aout_on <= 1'b1;
        end else begin
            low_count <= next_low_count;
            pd_q <= next_pd;
            aout_on <= next_aout_on;
        end
    end

    always_comb begin
        next_phase = phase;
        next_count = count;
        next_held = held;
        next_result = result;
        next_busy = busy_q;
        if (in_reset) begin
            // Abort at once, whatever the phase
            next_phase = sarcc_pkg::sarcc_sample;
            next_busy = 1'b0;
            next_count = '0;
        end else begin
            case (phase)
                sarcc_pkg::sarcc_sample: begin
                    if (start_fall) begin
                        next_held = sample_code;
                        next_busy = 1'b1;
                        next_count = '0;
                        next_phase = sarcc_pkg::sarcc_convert;
                    end
                end
                sarcc_pkg::sarcc_convert: begin
                    // Further strobes ignored until done
                    next_count = count + 1'b1;
                    if (count == sarcc_pkg::count_width'(
                            sarcc_pkg::conversion_cycles - 2)) begin
                        next_result = held;
                        next_busy = 1'b0;
                        next_phase = start_high ?
                            sarcc_pkg::sarcc_sample :
                            sarcc_pkg::sarcc_hold_wait;
                    end
                end
                sarcc_pkg::sarcc_hold_wait: begin
                    if (start_high)
                        next_phase = sarcc_pkg::sarcc_sample;
                end
                default: next_phase = sarcc_pkg::sarcc_sample;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            phase <= sarcc_pkg::sarcc_sample;
            count <= '0;
            held <= sarcc_pkg::result_reset;
            result <= sarcc_pkg::result_reset;
            busy_q <= 1'b0;
        end else begin
            phase <= next_phase;
            count <= next_count;
            held <= next_held;
            result <= next_result;
            busy_q <= next_busy;
        end
    end

    // Connection follows the next phase so it cuts off as busy rises
    always_comb begin
        next_start_prev = start_high;
        // Drive only on select and read low
        next_bus_en = read_on;
        next_bus_out = next_bus_en ? result : 16'h0000;
        next_connected = is_sampling(next_phase);
        next_hold = start_fall && !in_reset && is_sampling(phase);
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            start_prev <= 1'b1;
            bus_out <= 16'h0000;
            bus_en <= 1'b0;
            connected <= 1'b1;
            hold_q <= 1'b0;
        end else begin
            start_prev <= next_start_prev;
            bus_out <= next_bus_out;
            bus_en <= next_bus_en;
            connected <= next_connected;
            hold_q <= next_hold;
        end
    end

    assign link.busy = busy_q;
    assign link.result_bus_out = bus_out;
    assign link.result_bus_enable = {16{bus_en}};
    assign input_connected = connected;
    assign hold_strobe = hold_q;
    assign converter_powered = !pd_q;
    assign analog_outputs_powered = aout_on;
endmodule : sarcc_device

// ---- rtl/sarcc_pkg.sv ----
package sarcc_pkg;
    localparam int clock_period_ns = 5;
    localparam int data_width = 16;
    // Conversion and link times in their own units
    localparam int conversion_time_ns = 180;
    localparam int start_low_min_ns = 20;
    localparam int start_high_min_ns = 100;
    localparam int reset_resume_ns = 100;
    localparam int powerdown_resume_us = 5;
    localparam int analog_resume_ms = 25;
    localparam int reset_only_max_ns = 500;
    localparam int powerdown_low_min_ns = 1500;
    localparam int quiet_before_ns = 30;
    localparam int quiet_after_ns = 10;
    // Longest time and analog resume round down, other least times round up
    localparam int conversion_cycles = conversion_time_ns / clock_period_ns;
    localparam int start_low_cycles =
        (start_low_min_ns + clock_period_ns - 1) / clock_period_ns;
    localparam int start_high_cycles =
        (start_high_min_ns + clock_period_ns - 1) / clock_period_ns;
    localparam int reset_resume_cycles =
        (reset_resume_ns + clock_period_ns - 1) / clock_period_ns;
    localparam int powerdown_resume_cycles =
        (powerdown_resume_us * 1000 + clock_period_ns - 1) / clock_period_ns;
    localparam int analog_resume_cycles =
        analog_resume_ms * 1000000 / clock_period_ns;
    localparam int powerdown_low_cycles =
        (powerdown_low_min_ns + clock_period_ns - 1) / clock_period_ns;
    localparam int quiet_before_cycles =
        (quiet_before_ns + clock_period_ns - 1) / clock_period_ns;
    localparam int quiet_after_cycles =
        (quiet_after_ns + clock_period_ns - 1) / clock_period_ns;
    localparam logic [15:0] result_reset = 16'h0000;
    localparam int count_width = 24;
    typedef enum logic [1:0] {
        sarcc_sample,
        sarcc_convert,
        sarcc_hold_wait
    } sarcc_phase_type;
    typedef enum logic [2:0] {
        sarcc_h_wake,
        sarcc_h_idle,
        sarcc_h_start,
        sarcc_h_busy,
        sarcc_h_read,
        sarcc_h_gap
    } sarcc_host_state_type;
endpackage : sarcc_pkg

// ---- rtl/sarcc_link.sv ----
`timescale 1ns/1ps
interface sarcc_link;
    logic conversion_start_n;
    logic reset_powerdown_n;
    logic analog_output_powerdown_n;
    logic chip_select_n;
    logic read_n;
    logic busy;
    logic [15:0] result_bus_out;
    logic [15:0] result_bus_enable;
    modport device (
        input conversion_start_n, reset_powerdown_n,
        input analog_output_powerdown_n, chip_select_n, read_n,
        output busy, result_bus_out, result_bus_enable
    );
    modport host (
        output conversion_start_n, reset_powerdown_n,
        output analog_output_powerdown_n, chip_select_n, read_n,
        input busy, result_bus_out, result_bus_enable
    );
endinterface : sarcc_link

// ---- rtl/sarcc_host.sv ----
`timescale 1ns/1ps
module sarcc_host #(
    parameter int unsigned wake_cycles = sarcc_pkg::powerdown_resume_cycles
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Link
    sarcc_link.host link,
    // User side
    input wire logic convert_request,
    input wire logic powerdown_request,
    input wire logic analog_powerdown_request,
    output logic ready,
    output logic [15:0] result,
    output logic result_valid
);
    logic [1:0] busy_sync;
    logic [15:0] bus_sample;
    sarcc_pkg::sarcc_host_state_type state, next_state;
    logic [sarcc_pkg::count_width-1:0] count, next_count;
    logic start_n, next_start_n, sel_n, next_sel_n;
    logic [15:0] next_result;
    logic next_valid, rpd_n, next_rpd_n;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            busy_sync <= 2'h0;
            bus_sample <= 16'h0000;
        end else begin
            busy_sync <= {busy_sync[0], link.busy};
            bus_sample <= link.result_bus_out;
        end
    end

    always_comb begin
        next_state = state;
        next_count = count + 1'b1;
        next_start_n = start_n;
        next_sel_n = sel_n;
        next_result = result;
        next_valid = 1'b0;
        next_rpd_n = !powerdown_request;
        case (state)
            sarcc_pkg::sarcc_h_wake: begin
                // Results not trusted until resume time passes
                if (count >= sarcc_pkg::count_width'(wake_cycles)) begin
                    next_state = sarcc_pkg::sarcc_h_idle;
                end
            end
            sarcc_pkg::sarcc_h_idle: begin
                next_count = '0;
                if (convert_request && !busy_sync[1]) begin
                    next_start_n = 1'b0;
                    next_state = sarcc_pkg::sarcc_h_start;
                end
            end
            sarcc_pkg::sarcc_h_start: begin
                // Strobe stays low while the request is held
                if (count >= sarcc_pkg::count_width'(
                        sarcc_pkg::start_low_cycles + 2) &&
                        !convert_request) begin
                    next_start_n = 1'b1;
                    next_count = '0;
                    next_state = sarcc_pkg::sarcc_h_busy;
                end
            end
            sarcc_pkg::sarcc_h_busy: begin
                if (count > 3 && !busy_sync[1]) begin
                    next_sel_n = 1'b0;
                    next_count = '0;
                    next_state = sarcc_pkg::sarcc_h_read;
                end
            end
            sarcc_pkg::sarcc_h_read: begin
                // Device registers sync plus output stage
                if (count == 5) begin
                    next_result = bus_sample;
                    next_valid = 1'b1;
                    next_sel_n = 1'b1;
                    next_count = '0;
                    next_state = sarcc_pkg::sarcc_h_gap;
                end
            end
            sarcc_pkg::sarcc_h_gap: begin
                // Keeps start high and reads away from next fall
                if (count >= sarcc_pkg::count_width'(
                        sarcc_pkg::start_high_cycles))
                    next_state = sarcc_pkg::sarcc_h_idle;
            end
            default: next_state = sarcc_pkg::sarcc_h_wake;
        endcase
        if (powerdown_request) begin
            next_state = sarcc_pkg::sarcc_h_wake;
            next_count = '0;
            next_start_n = 1'b1;
            next_sel_n = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state <= sarcc_pkg::sarcc_h_wake;
            count <= '0;
            start_n <= 1'b1;
            sel_n <= 1'b1;
            result <= sarcc_pkg::result_reset;
            result_valid <= 1'b0;
            rpd_n <= 1'b1;
        end else begin
            state <= next_state;
            count <= next_count;
            start_n <= next_start_n;
            sel_n <= next_sel_n;
            result <= next_result;
            result_valid <= next_valid;
            rpd_n <= next_rpd_n;
        end
    end

    assign ready = (state == sarcc_pkg::sarcc_h_idle);
    assign link.conversion_start_n = start_n;
    assign link.chip_select_n = sel_n;
    assign link.read_n = sel_n;
    assign link.reset_powerdown_n = rpd_n;
    // Analog outputs need 25 ms after release; user must wait
    assign link.analog_output_powerdown_n = !analog_powerdown_request;
endmodule : sarcc_host

// ---- testbench/sarcc_props.sv ----
`timescale 1ns/1ps
module sarcc_props (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Link
    input wire logic conversion_start_n,
    input wire logic reset_powerdown_n,
    input wire logic analog_output_powerdown_n,
    input wire logic chip_select_n,
    input wire logic read_n,
    input wire logic busy,
    input wire logic [15:0] result_bus_out,
    input wire logic [15:0] result_bus_enable
);
    logic [7:0] busy_count;
    logic [7:0] next_busy_count;
    logic rd_on;
    assign rd_on = !chip_select_n && !read_n;
    always_comb next_busy_count = busy ? busy_count + 8'h01 : 8'h00;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            busy_count <= 8'h00;
        end else begin
            busy_count <= next_busy_count;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // Bus lags the strobes by up to three cycles
    a_bus_release: assert property (
        (!rd_on)[*4] |-> result_bus_enable == 16'h0000)
        else $error("bus driven without read");
    a_bus_drive: assert property (
        rd_on[*4] |-> result_bus_enable == 16'hFFFF)
        else $error("bus not driven during read");
    a_bus_zero: assert property (
        result_bus_enable == 16'h0000 |-> result_bus_out == 16'h0000)
        else $error("data shown while released");
    a_busy_cause: assert property (
        $rose(busy) |-> $past(conversion_start_n, 2) == 1'b0)
        else $error("busy rose without start");
    a_busy_prompt: assert property (
        $fell(conversion_start_n) && !busy && reset_powerdown_n
        |-> ##[1:4] (busy || !reset_powerdown_n))
        else $error("busy late after start");
    a_busy_hold: assert property (
        $rose(busy) |-> (busy || !reset_powerdown_n)[*8])
        else $error("busy dropped early");
    a_busy_span: assert property (busy_count <= 8'h24)
        else $error("conversion too long");
    a_no_early_end: assert property (
        $fell(busy) && reset_powerdown_n |-> busy_count >= 8'h21)
        else $error("conversion ended early");
    a_abort_fast: assert property (
        $fell(reset_powerdown_n) |-> ##[0:4] !busy)
        else $error("abort too slow");
    a_start_low: assert property (
        $fell(conversion_start_n) |-> (!conversion_start_n)[*4])
        else $error("start strobe too short");
    a_start_idle: assert property (
        $fell(conversion_start_n) |-> !busy)
        else $error("start while busy");
    c_convert: cover property ($fell(busy));
    c_abort: cover property ($fell(reset_powerdown_n) && busy);
    c_read: cover property (rd_on && result_bus_enable[0]);
    c_full_off: cover property (
        !analog_output_powerdown_n && !reset_powerdown_n);
endmodule : sarcc_props

// ---- testbench/tb_sar_conversion_control.sv ----
`timescale 1ns/1ps
module tb_sar_conversion_control;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic convert_request = 1'b0;
    logic powerdown_request = 1'b0;
    logic analog_powerdown_request = 1'b0;
    logic signed [15:0] sample_code = 16'h0000;
    logic input_connected, hold_strobe;
    logic converter_powered, analog_outputs_powered;
    logic ready, result_valid;
    logic [15:0] result;
    logic [31:0] seed = 32'h5719FFD0;
    logic [15:0] corner [4] = '{16'h7FFF, 16'h8000, 16'h0000, 16'hFFFF};
    int err_count = 0;
    int checked = 0;
    int holds = 0;
    int starts = 0;
    int hold_len = 1;
    sarcc_link link ();
    sarcc_device i_sarcc_device (.clock(clock), .reset(reset),
        .link(link.device), .sample_code(sample_code),
        .input_connected(input_connected), .hold_strobe(hold_strobe),
        .converter_powered(converter_powered),
        .analog_outputs_powered(analog_outputs_powered));
    sarcc_host i_sarcc_host (.clock(clock),
        .reset(reset), .link(link.host),
        .convert_request(convert_request),
        .powerdown_request(powerdown_request),
        .analog_powerdown_request(analog_powerdown_request),
        .ready(ready), .result(result), .result_valid(result_valid));
    sarcc_props u_props (.clock(clock), .reset(reset),
        .conversion_start_n(link.conversion_start_n),
        .reset_powerdown_n(link.reset_powerdown_n),
        .analog_output_powerdown_n(link.analog_output_powerdown_n),
        .chip_select_n(link.chip_select_n), .read_n(link.read_n),
        .busy(link.busy), .result_bus_out(link.result_bus_out),
        .result_bus_enable(link.result_bus_enable));
    initial begin
        forever #2.5 clock = ~clock;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Two's complement word leaves the bus as captured
    function automatic logic [15:0] expect_word(input logic [15:0] v);
        return v;
    endfunction : expect_word
    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask : check
    task automatic wait_ready();
        int n;
        n = 0;
        @(negedge clock);
        while (ready !== 1'b1 && n < 2000) begin
            @(negedge clock);
            n++;
        end
        check("ready", 16'h0001, {15'h0000, ready});
    endtask : wait_ready
    task automatic do_conv(input logic [15:0] code);
        int n;
        n = 0;
        wait_ready();
        check("bus_off", 16'h0000, link.result_bus_enable);
        @(posedge clock);
        sample_code <= code;
        convert_request <= 1'b1;
        repeat (hold_len) @(posedge clock);
        if (hold_len > 40) begin
            // Strobe still low after the end: input stays cut off
            @(negedge clock);
            check("waiting", 16'h0000, {15'h0000, input_connected});
            @(posedge clock);
        end
        convert_request <= 1'b0;
        starts++;
        while (result_valid !== 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
        end
        check("result", expect_word(code), result);
        check("sampling", 16'h0001, {15'h0000, input_connected});
    endtask : do_conv
    task automatic tally_and_finish();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // Inputs stay cut off while busy
    always @(negedge clock) begin
        if (hold_strobe === 1'b1) holds++;
        if (link.busy === 1'b1 && input_connected !== 1'b0) begin
            check("isolated", 16'h0000, {15'h0000, input_connected});
        end
    end
    initial begin
        #200000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        foreach (corner[i]) do_conv(corner[i]);
        repeat (16) begin
            seed = lfsr(seed);
            do_conv(seed[15:0]);
        end
        hold_len = 50;
        do_conv(16'h4321);
        hold_len = 1;
        // Short pulse mid-conversion aborts but keeps power
        wait_ready();
        @(posedge clock) convert_request <= 1'b1;
        @(posedge clock) convert_request <= 1'b0;
        starts++;
        repeat (20) @(posedge clock);
        powerdown_request <= 1'b1;
        repeat (10) @(posedge clock);
        powerdown_request <= 1'b0;
        @(negedge clock);
        check("abort", 16'h0000, {15'h0000, link.busy});
        check("power", 16'h0001, {15'h0000, converter_powered});
        do_conv(16'h1234);
        @(posedge clock) powerdown_request <= 1'b1;
        repeat (200) @(posedge clock);
        analog_powerdown_request <= 1'b1;
        repeat (400) @(posedge clock);
        @(negedge clock);
        check("off", 16'h0000, {15'h0000, converter_powered});
        check("aoff", 16'h0000, {15'h0000, analog_outputs_powered});
        @(posedge clock);
        powerdown_request <= 1'b0;
        analog_powerdown_request <= 1'b0;
        repeat (sarcc_pkg::powerdown_resume_cycles - 10) @(posedge clock);
        @(negedge clock);
        check("early", 16'h0000, {15'h0000, ready});
        do_conv(16'h8001);
        check("holds", 16'(starts), 16'(holds));
        tally_and_finish();
    end
endmodule : tb_sar_conversion_control
